//--- tcs_consts.svh
// Register offsets, field positions and reset values of the transmit control block
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TCS_ADDR_INTERP 12'h106
`define TCS_ADDR_MIXER 12'h107
`define TCS_ADDR_ROUTE 12'h108
`define TCS_ADDR_ALIGN_OFF 12'h10b
`define TCS_ADDR_ALIGN_SRC 12'h10c
`define TCS_ADDR_SOFT_ALIGN 12'h10d
`define TCS_ADDR_STATUS 12'h140
`define TCS_RESET_BYTE 8'h00
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TCS_B_INTERP_APPLY 2
`define TCS_B_A1_HP 3
`define TCS_B_A2_HP 4
`define TCS_B_B1_HP 5
`define TCS_B_B2_HP 6
`define TCS_B_MIX_EN 0
`define TCS_B_MIX_STEP 3
`define TCS_B_DIV_STEP 5
`define TCS_B_DROOP_EN 6
`define TCS_B_DROOP_APPLY 7
`define TCS_B_GLOBAL_OFF 5
`define TCS_B_MIX_SRC 7
`define TCS_B_GLOBAL_SRC 6
`define TCS_B_GLOBAL_SOFT 6
// Block indices, shared by disable bits, soft bits and source bits other than the mixer's
`define TCS_BLK_FIFO 0
`define TCS_BLK_MIX 1
`define TCS_BLK_DIV 2
`define TCS_BLK_OFF 3
`define TCS_BLK_GP 4
// ---------------------------------------------------------------
// Pointer gap after a buffer alignment
// ---------------------------------------------------------------
`define TCS_FIFO_GAP 3'h4
`endif

//--- tcs_pkg.sv
// Types shared by the transmit control block files
package tcs_pkg;
  // One sample for each channel
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
  } sample_pair_type;
  // Coarse mixer shift selection
  typedef enum logic [1:0] {
    MIX_LOWPASS = 2'b00,
    MIX_HALF = 2'b01,
    MIX_PLUS_QTR = 2'b10,
    MIX_MINUS_QTR = 2'b11
  } mix_sel_type;
  // Output routing selection
  typedef enum logic [1:0] {
    ROUTE_NORMAL = 2'b00,
    ROUTE_BOTH_A = 2'b01,
    ROUTE_BOTH_B = 2'b10,
    ROUTE_SWAP = 2'b11
  } route_type;
endpackage : tcs_pkg

//--- tcs_pair_buffer.sv
// Two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module tcs_pair_buffer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Filling side
  input wire logic i_valid,
  input wire tcs_pkg::sample_pair_type i_data,
  output logic o_ready,
  // Draining side
  output logic o_valid,
  output tcs_pkg::sample_pair_type o_data,
  input wire logic i_ready
);
  tcs_pkg::sample_pair_type mem [2];
  tcs_pkg::sample_pair_type next_mem [2];
  logic [1:0] count, next_count;
  logic wr_idx, next_wr_idx, rd_idx, next_rd_idx, next_ready;
  logic push, pop;

  // Handshakes on both sides
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_idx];

  // Next pointers, count and storage
  always_comb begin
    next_mem = mem;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_count = count;
    if (push) begin
      next_mem[wr_idx] = i_data;
      next_wr_idx = ~wr_idx;
    end
    if (pop) begin
      next_rd_idx = ~rd_idx;
    end
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
    next_ready = (next_count != 2'h2);
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      count <= 2'h0;
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      o_ready <= 1'b0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      count <= next_count;
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      o_ready <= next_ready;
      mem <= next_mem;
    end
  end

  AST_BUF_NO_OVERFILL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    count == 2'h2 |-> !o_ready) else $error("buffer full but ready");
endmodule : tcs_pair_buffer

//--- tcs_tx_ctrl.sv
// Transmit chain mode, routing and alignment control
`timescale 1ns/1ps
`include "tcs_consts.svh"

module tcs_tx_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Register write and read port
  input wire logic i_reg_wr_en,
  input wire logic [11:0] i_reg_addr,
  input wire logic [7:0] i_reg_wr_data,
  output logic [7:0] o_reg_rd_data,
  // Alignment pin
  input wire logic i_sync_pin,
  // Baseband samples
  input wire logic i_sample_valid,
  input wire tcs_pkg::sample_pair_type i_sample,
  output logic o_sample_ready,
  // DAC samples and block controls
  output tcs_pkg::sample_pair_type o_dac,
  output logic o_dac_valid,
  output logic o_droop_comp_active,
  output logic o_offset_corr_sync,
  output logic o_gainphase_corr_sync
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] interp_filter_cfg, next_interp_filter_cfg;
  logic [7:0] coarse_mixer_cfg, next_coarse_mixer_cfg;
  logic [7:0] route_divider_sinc_cfg, next_route_divider_sinc_cfg;
  logic [7:0] sync_disable_cfg, next_sync_disable_cfg;
  logic [7:0] align_src_cfg, next_align_src_cfg;
  logic [7:0] soft_align, next_soft_align;
  logic [7:0] next_rd_data;
  logic pin_s1, pin_s2, pin_s3, pin_level, next_pin_level, pin_rise;
  logic [7:0] soft_prev;
  logic mix_step_prev, div_step_prev, mix_step_rise, div_step_rise;
  logic [7:0] soft_rise;
  logic global_off, glob_evt;
  logic [4:0] src_vec, blk_sync;
  logic mix_step_ok, div_step_ok;
  logic [1:0] interp_code, div_mask;
  logic [1:0] div_ctr, next_div_ctr, mix_phase, next_mix_phase;
  logic [2:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic tick, buf_valid, pop, have_data, next_have_data;
  tcs_pkg::sample_pair_type buf_data, hold, next_hold, next_dac;
  tcs_pkg::sample_pair_type staged, mixed;
  logic next_droop;
  tcs_pkg::mix_sel_type mix_sel;
  tcs_pkg::route_type route_sel;

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Writes through the register port
  always_comb begin
    next_interp_filter_cfg = interp_filter_cfg;
    next_coarse_mixer_cfg = coarse_mixer_cfg;
    next_route_divider_sinc_cfg = route_divider_sinc_cfg;
    next_sync_disable_cfg = sync_disable_cfg;
    next_align_src_cfg = align_src_cfg;
    next_soft_align = soft_align;
    if (i_reg_wr_en) begin
      case (i_reg_addr)
        `TCS_ADDR_INTERP: next_interp_filter_cfg = i_reg_wr_data;
        `TCS_ADDR_MIXER: next_coarse_mixer_cfg = i_reg_wr_data;
        `TCS_ADDR_ROUTE: next_route_divider_sinc_cfg = i_reg_wr_data;
        `TCS_ADDR_ALIGN_OFF: next_sync_disable_cfg = i_reg_wr_data;
        `TCS_ADDR_ALIGN_SRC: next_align_src_cfg = i_reg_wr_data;
        `TCS_ADDR_SOFT_ALIGN: next_soft_align = i_reg_wr_data;
        default: ;
      endcase
    end
  end

  // Read data, status shows live phases and pointer gap
  always_comb begin
    case (i_reg_addr)
      `TCS_ADDR_INTERP: next_rd_data = interp_filter_cfg;
      `TCS_ADDR_MIXER: next_rd_data = coarse_mixer_cfg;
      `TCS_ADDR_ROUTE: next_rd_data = route_divider_sinc_cfg;
      `TCS_ADDR_ALIGN_OFF: next_rd_data = sync_disable_cfg;
      `TCS_ADDR_ALIGN_SRC: next_rd_data = align_src_cfg;
      `TCS_ADDR_SOFT_ALIGN: next_rd_data = soft_align;
      `TCS_ADDR_STATUS: next_rd_data = {mix_phase, div_ctr, o_droop_comp_active,
                                        3'(wr_ptr - rd_ptr)};
      default: next_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      interp_filter_cfg <= `TCS_RESET_BYTE;
      coarse_mixer_cfg <= `TCS_RESET_BYTE;
      route_divider_sinc_cfg <= `TCS_RESET_BYTE;
      sync_disable_cfg <= `TCS_RESET_BYTE;
      align_src_cfg <= `TCS_RESET_BYTE;
      soft_align <= `TCS_RESET_BYTE;
      o_reg_rd_data <= 8'h00;
    end else begin
      interp_filter_cfg <= next_interp_filter_cfg;
      coarse_mixer_cfg <= next_coarse_mixer_cfg;
      route_divider_sinc_cfg <= next_route_divider_sinc_cfg;
      sync_disable_cfg <= next_sync_disable_cfg;
      align_src_cfg <= next_align_src_cfg;
      soft_align <= next_soft_align;
      o_reg_rd_data <= next_rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Alignment events
  // ---------------------------------------------------------------
  // Pin level accepted once second and third stage agree
  always_comb begin
    next_pin_level = (pin_s2 == pin_s3) ? pin_s3 : pin_level;
  end
  assign pin_rise = next_pin_level & ~pin_level;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      pin_level <= 1'b0;
      soft_prev <= 8'h00;
      mix_step_prev <= 1'b0;
      div_step_prev <= 1'b0;
    end else begin
      pin_s1 <= i_sync_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_level <= next_pin_level;
      soft_prev <= soft_align;
      mix_step_prev <= coarse_mixer_cfg[`TCS_B_MIX_STEP];
      div_step_prev <= route_divider_sinc_cfg[`TCS_B_DIV_STEP];
    end
  end

  assign soft_rise = soft_align & ~soft_prev;
  assign mix_step_rise = coarse_mixer_cfg[`TCS_B_MIX_STEP] & ~mix_step_prev;
  assign div_step_rise = route_divider_sinc_cfg[`TCS_B_DIV_STEP] & ~div_step_prev;

  // global event from pin or soft bit
  assign global_off = sync_disable_cfg[`TCS_B_GLOBAL_OFF];
  assign glob_evt = align_src_cfg[`TCS_B_GLOBAL_SRC] ?
                    soft_rise[`TCS_B_GLOBAL_SOFT] : pin_rise;
  // mixer source lives beside the disables
  assign src_vec = {align_src_cfg[4:2], sync_disable_cfg[`TCS_B_MIX_SRC],
                    align_src_cfg[0]};

  // Per-block alignment decision
  for (genvar i = 0; i < 5; i++) begin : g_blk
    // block disable honoured with global off
    assign blk_sync[i] = global_off ?
      (~sync_disable_cfg[i] & (src_vec[i] ? soft_rise[i] : pin_rise)) : glob_evt;
  end

  assign mix_step_ok = mix_step_rise & global_off & sync_disable_cfg[`TCS_BLK_MIX];
  assign div_step_ok = div_step_rise & global_off & sync_disable_cfg[`TCS_BLK_DIV];

  // ---------------------------------------------------------------
  // Divider, mixer phase and sample path
  // ---------------------------------------------------------------
  // factor code used only when applied
  assign interp_code = interp_filter_cfg[`TCS_B_INTERP_APPLY] ?
                       interp_filter_cfg[1:0] : 2'h0;
  assign div_mask = (interp_code == 2'h0) ? 2'h0 :
                    (interp_code == 2'h1) ? 2'h1 : 2'h3;
  assign tick = (div_ctr == 2'h0);
  assign pop = tick & buf_valid;
  assign mix_sel = tcs_pkg::mix_sel_type'(coarse_mixer_cfg[2:1]);
  assign route_sel = tcs_pkg::route_type'(route_divider_sinc_cfg[1:0]);

  tcs_pair_buffer u_buffer (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_valid(i_sample_valid),
    .i_data(i_sample),
    .o_ready(o_sample_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(tick)
  );

  // Interpolation stages with high-pass sign flips
  always_comb begin
    staged = hold;
    // stage one at 2, both at 4
    // high-pass bits per stage and channel
    if (interp_code == 2'h1) begin
      if (interp_filter_cfg[`TCS_B_A1_HP] && div_ctr[0]) staged.a = 12'(-staged.a);
      if (interp_filter_cfg[`TCS_B_B1_HP] && div_ctr[0]) staged.b = 12'(-staged.b);
    end else if (interp_code != 2'h0) begin
      if (interp_filter_cfg[`TCS_B_A1_HP] && div_ctr[1]) staged.a = 12'(-staged.a);
      if (interp_filter_cfg[`TCS_B_B1_HP] && div_ctr[1]) staged.b = 12'(-staged.b);
      if (interp_filter_cfg[`TCS_B_A2_HP] && div_ctr[0]) staged.a = 12'(-staged.a);
      if (interp_filter_cfg[`TCS_B_B2_HP] && div_ctr[0]) staged.b = 12'(-staged.b);
    end
  end

  // Coarse mixer and routing
  always_comb begin
    mixed = staged;
    if (coarse_mixer_cfg[`TCS_B_MIX_EN]) begin
      unique case (mix_sel)
        tcs_pkg::MIX_LOWPASS: mixed = staged;
        tcs_pkg::MIX_HALF: begin
          if (mix_phase[0]) begin
            mixed.a = 12'(-staged.a);
            mixed.b = 12'(-staged.b);
          end
        end
        tcs_pkg::MIX_PLUS_QTR, tcs_pkg::MIX_MINUS_QTR: begin
          unique case ((mix_sel == tcs_pkg::MIX_PLUS_QTR) ? mix_phase : 2'(-mix_phase))
            2'h0: mixed = staged;
            2'h1: mixed = '{a: 12'(-staged.b), b: staged.a};
            2'h2: mixed = '{a: 12'(-staged.a), b: 12'(-staged.b)};
            2'h3: mixed = '{a: staged.b, b: 12'(-staged.a)};
          endcase
        end
      endcase
    end
    unique case (route_sel)
      tcs_pkg::ROUTE_NORMAL: next_dac = mixed;
      tcs_pkg::ROUTE_BOTH_A: next_dac = '{a: mixed.a, b: mixed.a};
      tcs_pkg::ROUTE_BOTH_B: next_dac = '{a: mixed.b, b: mixed.b};
      tcs_pkg::ROUTE_SWAP: next_dac = '{a: mixed.b, b: mixed.a};
    endcase
  end

  // Next divider, phase, pointers and held sample
  always_comb begin
    if (blk_sync[`TCS_BLK_DIV]) begin
      next_div_ctr = route_divider_sinc_cfg[4:3] & div_mask;
    end else begin
      next_div_ctr = 2'(div_ctr + 2'h1 + {1'b0, div_step_ok}) & div_mask;
    end
    if (blk_sync[`TCS_BLK_MIX]) begin
      next_mix_phase = coarse_mixer_cfg[5:4];
    end else begin
      next_mix_phase = 2'(mix_phase + 2'h1 + {1'b0, mix_step_ok});
    end
    next_wr_ptr = wr_ptr + {2'h0, i_sample_valid & o_sample_ready};
    next_rd_ptr = rd_ptr + {2'h0, pop};
    if (blk_sync[`TCS_BLK_FIFO]) begin
      next_rd_ptr = 3'h0;
      next_wr_ptr = `TCS_FIFO_GAP;
    end
    next_hold = pop ? buf_data : hold;
    next_have_data = have_data | pop;
    // droop state follows only when applied
    next_droop = route_divider_sinc_cfg[`TCS_B_DROOP_APPLY] ?
                 route_divider_sinc_cfg[`TCS_B_DROOP_EN] : o_droop_comp_active;
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      div_ctr <= 2'h0;
      mix_phase <= 2'h0;
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      hold <= '0;
      have_data <= 1'b0;
      o_dac <= '0;
      o_dac_valid <= 1'b0;
      o_droop_comp_active <= 1'b0;
      o_offset_corr_sync <= 1'b0;
      o_gainphase_corr_sync <= 1'b0;
    end else begin
      div_ctr <= next_div_ctr;
      mix_phase <= next_mix_phase;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      hold <= next_hold;
      have_data <= next_have_data;
      o_dac <= next_dac;
      o_dac_valid <= have_data;
      o_droop_comp_active <= next_droop;
      o_offset_corr_sync <= blk_sync[`TCS_BLK_OFF];
      o_gainphase_corr_sync <= blk_sync[`TCS_BLK_GP];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_UNAPPLIED_FACTOR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !interp_filter_cfg[`TCS_B_INTERP_APPLY] |=> div_ctr == 2'h0)
    else $error("unapplied factor still divides");
  AST_STAGE1_HP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (interp_code == 2'h1 && interp_filter_cfg[`TCS_B_A1_HP] && div_ctr == 2'h1 &&
     !coarse_mixer_cfg[`TCS_B_MIX_EN] && route_sel == tcs_pkg::ROUTE_NORMAL)
    |=> o_dac.a == 12'(-$past(hold.a))) else $error("stage one high-pass not applied");
  AST_MIX_OFF_PASS: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!coarse_mixer_cfg[`TCS_B_MIX_EN] && interp_code == 2'h0 &&
     route_sel == tcs_pkg::ROUTE_NORMAL) |=> o_dac == $past(hold))
    else $error("disabled mixer altered data");
  AST_MIX_STEP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (mix_step_ok && !blk_sync[`TCS_BLK_MIX]) |=> mix_phase == 2'($past(mix_phase) + 2'h2))
    else $error("mixer step did not advance phase");
  AST_MIX_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    blk_sync[`TCS_BLK_MIX] |=> mix_phase == $past(coarse_mixer_cfg[5:4]))
    else $error("mixer phase not loaded");
  AST_DIV_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    blk_sync[`TCS_BLK_DIV] |=> div_ctr == $past(route_divider_sinc_cfg[4:3] & div_mask))
    else $error("divider phase not loaded");
  AST_DROOP_HOLD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !route_divider_sinc_cfg[`TCS_B_DROOP_APPLY] |=> $stable(o_droop_comp_active))
    else $error("droop state changed without apply");
  AST_GLOBAL_ALL: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (!global_off && glob_evt) |-> blk_sync == 5'h1f)
    else $error("global event missed a block");
  AST_BLOCK_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (global_off && sync_disable_cfg[`TCS_BLK_MIX]) |-> !blk_sync[`TCS_BLK_MIX])
    else $error("disabled block aligned");
  AST_FIFO_GAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    blk_sync[`TCS_BLK_FIFO] |=> 3'(wr_ptr - rd_ptr) == `TCS_FIFO_GAP)
    else $error("pointer gap not four");
  AST_SOFT_PULSE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    soft_rise[`TCS_BLK_MIX] |=> !soft_rise[`TCS_BLK_MIX])
    else $error("soft rise longer than one cycle");
endmodule : tcs_tx_ctrl

//--- tcs_sample_source.sv
// Baseband sample source model feeding the transmit control block
`timescale 1ns/1ps
module tcs_sample_source (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Handshake towards the block
  input wire logic i_ready,
  output logic o_valid,
  output tcs_pkg::sample_pair_type o_sample
);
  tcs_pkg::sample_pair_type pending[$];
  int gap = 0;
  int idle = 0;

  // Queue one pair for offering
  task automatic push_pair(input tcs_pkg::sample_pair_type p);
    pending.push_back(p);
  endtask : push_pair

  initial begin
    o_valid = 1'b0;
    o_sample = 24'h000000;
  end

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
      idle <= 0;
    end else if (o_valid && !i_ready) begin
      idle <= 0; // Hold offer until taken
    end else if (pending.size() > 0 && idle >= gap) begin
      o_valid <= 1'b1;
      o_sample <= pending.pop_front();
      idle <= 0;
    end else begin
      o_valid <= 1'b0;
      o_sample <= ~o_sample; // Released lines flip each idle cycle, showing the stale pair every other cycle
      idle <= idle + 1;
    end
  end
endmodule : tcs_sample_source

//--- tcs_tx_ctrl_tb.sv
// Self-checking bench of the transmit control block
`timescale 1ns/1ps
module tcs_tx_ctrl_tb;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reg_wr_en = 1'b0;
  logic [11:0] i_reg_addr = 12'h000;
  logic [7:0] i_reg_wr_data = 8'h00;
  logic i_sync_pin = 1'b0;
  logic i_sample_valid;
  tcs_pkg::sample_pair_type i_sample;
  logic [7:0] o_reg_rd_data;
  logic o_sample_ready, o_dac_valid, o_droop_comp_active;
  logic o_offset_corr_sync, o_gainphase_corr_sync;
  tcs_pkg::sample_pair_type o_dac;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [7:0] got;
  logic [7:0] n_off, n_gp;
  logic saw_full;
  logic [7:0] prev;
  // Register rows: address, written byte, expected read back
  logic [11:0] row_addr [9] = '{12'h106, 12'h107, 12'h108, 12'h10b, 12'h1ff,
    12'h106, 12'h107, 12'h108, 12'h10b};
  logic [7:0] row_wr [9] = '{8'h5b, 8'h37, 8'hfb, 8'hbf, 8'haa, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] row_rd [9] = '{8'h5b, 8'h37, 8'hfb, 8'hbf, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Alignment rows: disables, sources, soft bits, expected offset and gain pulses
  logic [7:0] al_dis [6] = '{8'h20, 8'h20, 8'h28, 8'h08, 8'h28, 8'h20};
  logic [7:0] al_src [6] = '{8'h19, 8'h19, 8'h19, 8'h40, 8'h40, 8'h01};
  logic [7:0] al_soft [6] = '{8'h08, 8'h10, 8'h08, 8'h40, 8'h40, 8'h01};
  logic [7:0] al_off [6] = '{8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] al_gp [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
  // Routing rows: expected DAC A and DAC B for each routing code
  logic [11:0] rt_a [4] = '{12'h123, 12'h123, 12'h456, 12'h456};
  logic [11:0] rt_b [4] = '{12'h456, 12'h123, 12'h456, 12'h123};

  tcs_tx_ctrl tcs_tx_ctrl_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_reg_wr_en(i_reg_wr_en), .i_reg_addr(i_reg_addr), .i_reg_wr_data(i_reg_wr_data),
    .o_reg_rd_data(o_reg_rd_data), .i_sync_pin(i_sync_pin), .i_sample_valid(i_sample_valid),
    .i_sample(i_sample), .o_sample_ready(o_sample_ready), .o_dac(o_dac),
    .o_dac_valid(o_dac_valid), .o_droop_comp_active(o_droop_comp_active),
    .o_offset_corr_sync(o_offset_corr_sync), .o_gainphase_corr_sync(o_gainphase_corr_sync));
  tcs_sample_source tcs_sample_source_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_ready(o_sample_ready), .o_valid(i_sample_valid), .o_sample(i_sample));

  // --------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------
  always #20 i_clk = ~i_clk;

  // Cut a hang short
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic cmp8(input logic [7:0] act, input logic [7:0] exp);
    checks_done++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %0t byte %h expected %h", $time, act, exp);
    end
  endtask : cmp8

  task automatic cmp_pair(input tcs_pkg::sample_pair_type act, input logic [23:0] exp);
    checks_done++;
    if (act !== exp) begin
      mismatches++;
      $display("BAD %0t dac pair %h expected %h", $time, act, exp);
    end
  endtask : cmp_pair

  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr_en <= 1'b1;
    i_reg_addr <= a;
    i_reg_wr_data <= d;
    @(posedge i_clk);
    i_reg_wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [11:0] a);
    @(posedge i_clk);
    i_reg_addr <= a;
    repeat (2) @(posedge i_clk);
    #1 got = o_reg_rd_data;
  endtask : reg_rd

  // Write soft bits, then count alignment pulses over eight cycles
  task automatic wr_count(input logic [7:0] d);
    reg_wr(12'h10d, d);
    n_off = 8'h00;
    n_gp = 8'h00;
    repeat (8) begin
      #1;
      n_off = n_off + {7'h00, o_offset_corr_sync};
      n_gp = n_gp + {7'h00, o_gainphase_corr_sync};
      @(posedge i_clk);
    end
  endtask : wr_count

  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (2) @(posedge i_clk);
    #1 cmp8({3'h0, o_sample_ready, o_dac_valid, o_droop_comp_active, o_offset_corr_sync,
      o_gainphase_corr_sync}, 8'h00);
    @(posedge i_clk);
    i_reset_n <= 1'b1;
    // Reset values of the four registers
    for (int i = 0; i < 4; i++) begin
      reg_rd(row_addr[i]);
      cmp8(got, 8'h00);
    end
    // Read back, unmapped place included
    for (int i = 0; i < 9; i++) begin
      reg_wr(row_addr[i], row_wr[i]);
      reg_rd(row_addr[i]);
      cmp8(got, row_rd[i]);
    end
    // droop enable needs its apply bit, held otherwise
    reg_wr(12'h108, 8'h80);
    repeat (3) @(posedge i_clk);
    #1 cmp8({7'h00, o_droop_comp_active}, 8'h00);
    reg_wr(12'h108, 8'h40);
    repeat (3) @(posedge i_clk);
    #1 cmp8({7'h00, o_droop_comp_active}, 8'h00);
    reg_wr(12'h108, 8'hc0);
    repeat (3) @(posedge i_clk);
    #1 cmp8({7'h00, o_droop_comp_active}, 8'h01);
    reg_wr(12'h108, 8'h40);
    repeat (3) @(posedge i_clk);
    #1 cmp8({7'h00, o_droop_comp_active}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      reg_wr(12'h10d, 8'h00);
      reg_wr(12'h10b, al_dis[i]);
      reg_wr(12'h10c, al_src[i]);
      wr_count(al_soft[i]);
      cmp8(n_off, al_off[i]);
      cmp8(n_gp, al_gp[i]);
    end
    // pin rise aligns every block with global on
    reg_wr(12'h10b, 8'h00);
    i_sync_pin <= 1'b1;
    wr_count(8'h00);
    cmp8(n_off, 8'h01);
    cmp8(n_gp, 8'h01);
    reg_rd(12'h140);
    cmp8({5'h00, got[2:0]}, 8'h04);
    reg_wr(12'h140, 8'hff);
    reg_rd(12'h140);
    cmp8({5'h00, got[2:0]}, 8'h04);
    // routing of one held pair, factor one
    tcs_sample_source_inst.push_pair({12'h123, 12'h456});
    for (int k = 0; k < 20 && o_dac_valid !== 1'b1; k++) @(posedge i_clk);
    #1 cmp8({7'h00, o_dac_valid}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      reg_wr(12'h108, i[7:0]);
      repeat (4) @(posedge i_clk);
      #1 cmp_pair(o_dac, {rt_a[i], rt_b[i]});
    end
    // factor four fills the buffer when offers run back to back
    for (int c = 2; c < 4; c++) begin
      reg_wr(12'h106, 8'h04 | c[7:0]);
      saw_full = 1'b0;
      repeat (6) tcs_sample_source_inst.push_pair({12'habc, 12'h321});
      repeat (30) begin
        @(posedge i_clk);
        #1 saw_full = saw_full | ~o_sample_ready;
      end
      cmp8({7'h00, saw_full}, 8'h01);
      cmp8({7'h00, o_sample_ready}, 8'h01);
    end
    // paced source at factor four never meets a full buffer
    tcs_sample_source_inst.gap = 3;
    saw_full = 1'b0;
    repeat (4) tcs_sample_source_inst.push_pair({12'h0f0, 12'h70f});
    repeat (24) begin
      @(posedge i_clk);
      #1 saw_full = saw_full | ~o_sample_ready;
    end
    cmp8({7'h00, saw_full}, 8'h00);
    // Steps add one phase: seven edges plus one each wraps to zero
    reg_wr(12'h10b, 8'h26);
    reg_rd(12'h140);
    prev = got;
    reg_wr(12'h107, 8'h08);
    reg_wr(12'h108, 8'h20);
    reg_rd(12'h140);
    cmp8({4'h0, got[7:4]}, {4'h0, prev[7:4]});
    // Factor two with channel A stage one high-pass
    reg_wr(12'h106, 8'h0d);
    n_off = 8'h00;
    n_gp = 8'h00;
    repeat (2) @(posedge i_clk);
    repeat (4) begin
      @(posedge i_clk);
      #1 n_off = n_off + {7'h00, o_dac.a == 12'hf10};
      n_gp = n_gp + {7'h00, o_dac.b == 12'h70f};
    end
    cmp8(n_off, 8'h02);
    cmp8(n_gp, 8'h04);
    complete_run();
  end
endmodule : tcs_tx_ctrl_tb
